/* File: design/mbid_slave.v */
/*
  serial-link slave for the device identification request and for the
  exception replies of a correctly received frame.
  assumes a byte receiver and transmitter outside: bytes arrive with a one-cycle
  rxValid and a parity flag, and leave through a txValid/txReady handshake.
*/
`timescale 1ns/1ps
`include "mbid_defines.vh"

module mbid_slave #(
   parameter T35_CYCLES = (`MBID_T35_NS + `MBID_CLK_NS - 1) / `MBID_CLK_NS,
   // identity texts: values are arbitrary
   parameter [31:0] VENDOR_TXT = 32'h4D414B52,
   parameter [79:0] PRODUCT_TXT = 80'h4452562D5820352E3041,
   parameter [39:0] REVISION_TXT = 40'h56312E3030
) (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // configuration
   input wire [7:0] slaveAddr,
   // receive byte stream
   input wire rxValid,
   input wire [7:0] rxData,
   input wire rxParityErr,
   // transmit byte stream
   output wire txValid,
   output wire [7:0] txData,
   input wire txReady,
   // status
   output wire frameDropped,
   output wire replyBusy
);

   // -------------------------------------------------------------------------
   // states
   // -------------------------------------------------------------------------
   localparam [8:0] S_IDLE = 9'h001;
   localparam [8:0] S_RX = 9'h002;
   localparam [8:0] S_EVAL = 9'h004;
   localparam [8:0] S_HDR = 9'h008;
   localparam [8:0] S_OCODE = 9'h010;
   localparam [8:0] S_OLEN = 9'h020;
   localparam [8:0] S_OVAL = 9'h040;
   localparam [8:0] S_CRCL = 9'h080;
   localparam [8:0] S_CRCH = 9'h100;

   // -------------------------------------------------------------------------
   // functions
   // -------------------------------------------------------------------------
   function [15:0] crc16;
      input [15:0] crc;
      input [7:0] data;
      integer b;
      reg [15:0] c;
      begin
         c = crc ^ {8'h00, data};
         for (b = 0; b < 8; b = b + 1) begin
            if (c[0])
               c = (c >> 1) ^ `MBID_CRC_POLY;
            else
               c = c >> 1;
         end
         crc16 = c;
      end
   endfunction

   function [3:0] objLen;
      input [1:0] obj;
      begin
         case (obj)
            2'h0: objLen = `MBID_LEN_VENDOR;
            2'h1: objLen = `MBID_LEN_PRODUCT;
            default: objLen = `MBID_LEN_REVISION;
         endcase
      end
   endfunction

   // first character sits in the top byte of each text
   function [7:0] objChar;
      input [1:0] obj;
      input [3:0] i;
      integer k;
      begin
         k = objLen(obj) - 1 - i;
         case (obj)
            2'h0: objChar = VENDOR_TXT[8*k +: 8];
            2'h1: objChar = PRODUCT_TXT[8*k +: 8];
            default: objChar = REVISION_TXT[8*k +: 8];
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------------
   reg [8:0] state_reg;
   reg [7:0] rxBuf [0:7];
   reg [7:0] hdr_reg [0:7];
   reg [7:0] rxCount_reg;
   reg rxBad_reg;
   reg [15:0] rxCrc_reg;
   reg [31:0] gapCnt_reg;
   reg [3:0] hdrLen_reg;
   reg [3:0] idx_reg;
   reg [1:0] obj_reg;
   reg [1:0] lastObj_reg;
   reg [15:0] txCrc_reg;
   reg txValid_reg;
   reg [7:0] txData_reg;
   reg dropped_reg;
   reg busy_reg;
   reg [7:0] curByte;

   wire [7:0] fnCode = rxBuf[1];
   wire [7:0] readCode = rxBuf[3];
   wire [7:0] objNum = rxBuf[4];
   wire addrHit = (rxBuf[0] == slaveAddr) && (slaveAddr != `MBID_BROADCAST);
   wire frameGood = !rxBad_reg && (rxCrc_reg == 16'h0000) && (rxCount_reg >= `MBID_MIN_LEN);
   wire isExc = (hdrLen_reg == `MBID_HDR_LEN_EXC);
   wire rcIndividual = (readCode == `MBID_RC_INDIVIDUAL);

   assign txValid = txValid_reg;
   assign txData = txData_reg;
   assign frameDropped = dropped_reg;
   assign replyBusy = busy_reg;

   // -------------------------------------------------------------------------
   // byte to send in the current state
   // -------------------------------------------------------------------------
   always @* begin
      case (state_reg)
         S_HDR: curByte = hdr_reg[idx_reg[2:0]];
         S_OCODE: curByte = {6'h00, obj_reg};
         S_OLEN: curByte = {4'h0, objLen(obj_reg)};
         S_OVAL: curByte = objChar(obj_reg, idx_reg);
         S_CRCL: curByte = txCrc_reg[7:0];
         S_CRCH: curByte = txCrc_reg[15:8];
         default: curByte = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= S_IDLE;
         rxCount_reg <= 8'h00;
         rxBad_reg <= 1'b0;
         rxCrc_reg <= `MBID_CRC_INIT;
         gapCnt_reg <= 32'h00000000;
         hdrLen_reg <= 4'h0;
         idx_reg <= 4'h0;
         obj_reg <= 2'h0;
         lastObj_reg <= 2'h0;
         txCrc_reg <= `MBID_CRC_INIT;
         txValid_reg <= 1'b0;
         txData_reg <= 8'h00;
         dropped_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         dropped_reg <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               busy_reg <= 1'b0;
               if (rxValid) begin
                  rxBuf[0] <= rxData;
                  rxCount_reg <= 8'h01;
                  rxCrc_reg <= crc16(`MBID_CRC_INIT, rxData);
                  rxBad_reg <= rxParityErr;
                  gapCnt_reg <= 32'h00000000;
                  state_reg <= S_RX;
               end
            end
            S_RX: begin
               if (rxValid) begin
                  if (rxCount_reg < 8'h08)
                     rxBuf[rxCount_reg[2:0]] <= rxData;
                  if (rxCount_reg != 8'hFF)
                     rxCount_reg <= rxCount_reg + 8'h01;
                  rxCrc_reg <= crc16(rxCrc_reg, rxData);
                  rxBad_reg <= rxBad_reg | rxParityErr;
                  gapCnt_reg <= 32'h00000000;
               end else if (gapCnt_reg == T35_CYCLES - 1) begin
                  // a silence this long closes the frame; an unfinished one fails crc
                  state_reg <= S_EVAL;
               end else begin
                  gapCnt_reg <= gapCnt_reg + 32'h00000001;
               end
            end
            S_EVAL: begin
               idx_reg <= 4'h0;
               txCrc_reg <= `MBID_CRC_INIT;
               hdr_reg[0] <= rxBuf[0];
               if (!frameGood || !addrHit) begin
                  dropped_reg <= addrHit | !frameGood;
                  state_reg <= S_IDLE;
               end else begin
                  busy_reg <= 1'b1;
                  state_reg <= S_HDR;
                  if (fnCode != `MBID_FN_READ_ID || rxBuf[2] != `MBID_MEI_DEV_ID) begin
                     hdr_reg[1] <= fnCode | `MBID_EXC_FLAG;
                     hdr_reg[2] <= `MBID_EXC_ILLEGAL_FN;
                     hdrLen_reg <= `MBID_HDR_LEN_EXC;
                  end else if (rxCount_reg != `MBID_REQ_LEN ||
                               (readCode != `MBID_RC_BASIC_SEQ && !rcIndividual)) begin
                     // no writes are served, so bad values and read codes are
                     // the only code 3 causes left
                     hdr_reg[1] <= fnCode | `MBID_EXC_FLAG;
                     hdr_reg[2] <= `MBID_EXC_BAD_VALUE;
                     hdrLen_reg <= `MBID_HDR_LEN_EXC;
                  end else if (objNum > {6'h00, `MBID_LAST_OBJECT}) begin
                     hdr_reg[1] <= fnCode | `MBID_EXC_FLAG;
                     hdr_reg[2] <= `MBID_EXC_BAD_ADDR;
                     hdrLen_reg <= `MBID_HDR_LEN_EXC;
                  end else begin
                     hdr_reg[1] <= `MBID_FN_READ_ID;
                     hdr_reg[2] <= `MBID_MEI_DEV_ID;
                     hdr_reg[3] <= readCode;
                     hdr_reg[4] <= `MBID_CONFORMITY;
                     hdr_reg[5] <= `MBID_MORE_FOLLOWS;
                     hdr_reg[6] <= `MBID_NEXT_OBJECT;
                     hdr_reg[7] <= rcIndividual ? 8'h01 :
                                   (8'h03 - objNum);
                     hdrLen_reg <= `MBID_HDR_LEN_ID;
                     obj_reg <= objNum[1:0];
                     lastObj_reg <= rcIndividual ? objNum[1:0] : `MBID_LAST_OBJECT;
                  end
               end
            end
            S_HDR, S_OCODE, S_OLEN, S_OVAL, S_CRCL, S_CRCH: begin
               if (!txValid_reg) begin
                  txData_reg <= curByte;
                  txValid_reg <= 1'b1;
                  if (state_reg != S_CRCL && state_reg != S_CRCH)
                     txCrc_reg <= crc16(txCrc_reg, curByte);
               end else if (txReady) begin
                  txValid_reg <= 1'b0;
                  case (state_reg)
                     S_HDR: begin
                        if (idx_reg == hdrLen_reg - 4'h1) begin
                           idx_reg <= 4'h0;
                           state_reg <= isExc ? S_CRCL : S_OCODE;
                        end else begin
                           idx_reg <= idx_reg + 4'h1;
                        end
                     end
                     S_OCODE: state_reg <= S_OLEN;
                     S_OLEN: state_reg <= S_OVAL;
                     S_OVAL: begin
                        if (idx_reg == objLen(obj_reg) - 4'h1) begin
                           idx_reg <= 4'h0;
                           if (obj_reg == lastObj_reg) begin
                              state_reg <= S_CRCL;
                           end else begin
                              obj_reg <= obj_reg + 2'h1;
                              state_reg <= S_OCODE;
                           end
                        end else begin
                           idx_reg <= idx_reg + 4'h1;
                        end
                     end
                     S_CRCL: state_reg <= S_CRCH;
                     default: begin
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                     end
                  endcase
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule // mbid_slave

/* File: dv/mbid_master_model.sv */
/* serial master model: sends request frames byte by byte, collects reply bytes.
   assumes the slave's byte ports and the 10 MHz clock. */
`timescale 1ns/1ps
`include "mbid_defines.vh"
module mbid_master_model #(
   parameter T35_CYCLES = 20
) (
   // clock
   input wire logic sys_clk,
   // request bytes
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxParityErr,
   // reply bytes
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   // stall control
   input wire logic stallEn
);
   integer seed = 32'h24B1E583;
   logic [7:0] replyQ[$];
   initial begin
      rxValid = 1'b0;
      rxData = 8'hA5;
      rxParityErr = 1'b0;
      txReady = 1'b1;
   end
   // random stalls exercise the slave's hold of an untaken byte
   always @(posedge sys_clk) begin
      if (txValid && txReady) replyQ.push_back(txData);
      txReady <= !stallEn || ($random(seed) % 3 != 0);
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = `MBID_CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `MBID_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // idle data line shows the inverse so a stale byte is never mistaken
   task automatic sendByte(input logic [7:0] b, input logic pe);
      @(posedge sys_clk);
      #1;
      rxValid = 1'b1;
      rxData = b;
      rxParityErr = pe;
      @(posedge sys_clk);
      #1;
      rxValid = 1'b0;
      rxData = ~b;
      rxParityErr = 1'b0;
   endtask
   task automatic sendFrame(input logic [7:0] q[$], input int peAt, input logic crcBad,
                            input int gapAt);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, crcBad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         if (i == gapAt) repeat (T35_CYCLES + 4) @(posedge sys_clk);
         sendByte(q[i], i == peAt);
      end
   endtask
endmodule // mbid_master_model

/* File: dv/mbid_slave_properties.sv */
/* pin checks for the identification slave: reply byte handshake, reply start, drops.
   assumes one clock, synchronous active-high reset, bound onto mbid_slave. */
`timescale 1ns/1ps
module mbid_slave_properties #(
   parameter T35_CYCLES = 20
) (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // configuration
   input wire [7:0] slaveAddr,
   // receive
   input wire rxValid,
   input wire [7:0] rxData,
   input wire rxParityErr,
   // transmit
   input wire txValid,
   input wire [7:0] txData,
   input wire txReady,
   // status
   input wire frameDropped,
   input wire replyBusy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [15:0] idleCnt;
   // saturates so a long idle line never wraps into a false short gap
   always @(posedge sys_clk) begin
      if (reset || rxValid) begin
         idleCnt <= 16'h0000;
      end else if (idleCnt != 16'hFFFF) begin
         idleCnt <= idleCnt + 16'h0001;
      end
   end
   sequence txTaken;
      txValid && txReady;
   endsequence
   sequence addrFirst;
      ##[0:2] txValid && txData == slaveAddr;
   endsequence
   a_tx_hold_offer: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply byte dropped before taken");
   a_tx_byte_gap: assert property (txTaken |=> !txValid)
      else $error("no idle cycle after reply byte");
   a_tx_inside_reply: assert property (txValid |-> replyBusy)
      else $error("reply byte outside reply");
   a_reply_addr_first: assert property ($rose(replyBusy) |-> addrFirst)
      else $error("reply does not open with own address");
   a_reply_after_quiet: assert property ($rose(replyBusy) |-> idleCnt >= T35_CYCLES)
      else $error("reply before frame silence");
   a_own_addr_only: assert property ($rose(replyBusy) |-> slaveAddr != 8'h00)
      else $error("reply with no own address");
   a_drop_pulse_one: assert property (frameDropped |=> !frameDropped)
      else $error("drop flag longer than one cycle");
   a_drop_no_reply: assert property (frameDropped |-> !replyBusy [*2])
      else $error("reply for a dropped frame");
   a_busy_ends_take: assert property ($fell(replyBusy) |-> $past(txValid) && $past(txReady))
      else $error("reply ended without last byte taken");
endmodule // mbid_slave_properties

bind mbid_slave mbid_slave_properties #(.T35_CYCLES(T35_CYCLES)) u_props (.sys_clk(sys_clk),
   .reset(reset), .slaveAddr(slaveAddr), .rxValid(rxValid), .rxData(rxData),
   .rxParityErr(rxParityErr), .txValid(txValid), .txData(txData), .txReady(txReady),
   .frameDropped(frameDropped), .replyBusy(replyBusy));

/* File: dv/mbid_slave_tb_top.sv */
/* bench for the identification slave: corner and random requests, reply compare.
   assumes the master model and the checker are compiled before it. */
`timescale 1ns/1ps
`include "mbid_defines.vh"
module mbid_slave_tb_top;
   localparam int T35 = 20;
   localparam logic [31:0] VTXT = 32'h4D414B52; // arbitrary value
   localparam logic [79:0] PTXT = 80'h4452562D5820352E3041; // arbitrary value
   localparam logic [39:0] RTXT = 40'h56312E3030; // arbitrary value
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] slaveAddr = 8'h01;
   logic stallEn = 1'b0;
   logic rxValid, rxParityErr, txValid, txReady, frameDropped, replyBusy;
   logic [7:0] rxData, txData;
   logic [7:0] reqQ[$], expQ[$];
   logic [7:0] rcTab[4] = '{8'h01, 8'h04, 8'h01, 8'h02};
   integer seed = 32'h24B1E583;
   int errors = 0, compares = 0, drops = 0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (frameDropped === 1'b1) drops <= drops + 1;
   mbid_slave #(.T35_CYCLES(T35), .VENDOR_TXT(VTXT), .PRODUCT_TXT(PTXT),
      .REVISION_TXT(RTXT)) dut (.sys_clk(sys_clk), .reset(reset), .slaveAddr(slaveAddr),
      .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxParityErr), .txValid(txValid),
      .txData(txData), .txReady(txReady), .frameDropped(frameDropped), .replyBusy(replyBusy));
   mbid_master_model #(.T35_CYCLES(T35)) master (.sys_clk(sys_clk), .rxValid(rxValid),
      .rxData(rxData), .rxParityErr(rxParityErr), .txValid(txValid), .txData(txData),
      .txReady(txReady), .stallEn(stallEn));
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic void build(input logic [7:0] fn, mei, rc, obj);
      int n, k;
      logic [15:0] c;
      if (fn !== `MBID_FN_READ_ID || mei !== `MBID_MEI_DEV_ID)
         expQ = {slaveAddr, fn | `MBID_EXC_FLAG, `MBID_EXC_ILLEGAL_FN};
      else if (rc !== 8'h01 && rc !== 8'h04)
         expQ = {slaveAddr, fn | `MBID_EXC_FLAG, `MBID_EXC_BAD_VALUE};
      else if (obj > 8'h02)
         expQ = {slaveAddr, fn | `MBID_EXC_FLAG, `MBID_EXC_BAD_ADDR};
      else begin
         n = (rc == 8'h04) ? 1 : 3 - obj;
         expQ = {slaveAddr, fn, mei, rc, `MBID_CONFORMITY, 8'h00, 8'h00, 8'(n)};
         for (int o = obj; o < obj + n; o++) begin
            k = (o == 0) ? `MBID_LEN_VENDOR : (o == 1) ? `MBID_LEN_PRODUCT : `MBID_LEN_REVISION;
            expQ.push_back(8'(o));
            expQ.push_back(8'(k));
            for (int i = 0; i < k; i++)
               expQ.push_back(o == 0 ? VTXT[31-8*i -: 8] : o == 1 ? PTXT[79-8*i -: 8] : RTXT[39-8*i -: 8]);
         end
      end
      c = master.crc16(expQ);
      expQ.push_back(c[7:0]);
      expQ.push_back(c[15:8]);
   endfunction
   // kind: 0 clean, 1 parity error, 2 bad crc, 3 silence inside the frame
   task automatic run(input logic [7:0] a, fn, mei, rc, obj, input int kind);
      int d0, w;
      d0 = drops;
      w = 0;
      master.replyQ.delete();
      reqQ = {a, fn, mei, rc, obj};
      build(fn, mei, rc, obj);
      if (kind != 0 || a !== slaveAddr) expQ.delete();
      master.sendFrame(reqQ, kind == 1 ? 2 : -1, kind == 2, kind == 3 ? 3 : -1);
      repeat (T35 + 4) @(posedge sys_clk);
      while (replyBusy !== 1'b0 && w < 1000) begin
         @(posedge sys_clk);
         w++;
      end
      repeat (3) @(posedge sys_clk);
      chk("reply end", 16'h0000, 16'(w == 1000));
      chk("reply length", 16'(expQ.size()), 16'(master.replyQ.size()));
      foreach (expQ[i]) if (i < master.replyQ.size()) chk("reply byte", expQ[i], master.replyQ[i]);
      if (kind != 0 && a === slaveAddr) chk("drops", 16'(d0 + (kind == 3 ? 2 : 1)), 16'(drops));
   endtask
   task end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #6000000;
      errors++;
      end_sim;
   end
   initial begin
      logic [31:0] r;
      repeat (10) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      for (int k = 0; k < 8; k++) run(8'h01, 8'h2B, 8'h0E, k[2] ? 8'h04 : 8'h01, 8'(k % 4), 0);
      run(8'h01, 8'h03, 8'h0E, 8'h01, 8'h00, 0);
      run(8'h01, 8'h2B, 8'h0D, 8'h01, 8'h00, 0);
      run(8'h01, 8'h2B, 8'h0E, 8'h02, 8'h00, 0);
      run(8'h01, 8'h2B, 8'h0E, 8'h01, 8'h00, 1);
      run(8'h01, 8'h2B, 8'h0E, 8'h01, 8'h00, 2);
      run(8'h01, 8'h2B, 8'h0E, 8'h01, 8'h00, 3);
      run(8'h02, 8'h2B, 8'h0E, 8'h01, 8'h00, 0);
      stallEn = 1'b1;
      repeat (24) begin
         #1;
         r = $random(seed);
         slaveAddr = 8'h01 + (r[7:0] % 8'hF7);
         run(r[8] ? slaveAddr : slaveAddr + 8'h01, r[11:9] == 3'h0 ? r[23:16] : 8'h2B, 8'h0E,
             rcTab[r[13:12]], {6'h00, r[15:14]}, 0);
      end
      end_sim;
   end
endmodule // mbid_slave_tb_top

/* File: include/mbid_defines.vh */
/*
  constants for the serial identification slave: frame codes, fixed reply bytes,
  crc settings and character-time figures.
  assumes a 10 MHz system clock and an 11-bit serial character.
*/
`ifndef MBID_DEFINES_VH
`define MBID_DEFINES_VH

// ----------------------------------------------------------------------------
// frame codes
// ----------------------------------------------------------------------------
`define MBID_FN_READ_ID 8'h2B
`define MBID_MEI_DEV_ID 8'h0E
`define MBID_RC_BASIC_SEQ 8'h01
`define MBID_RC_INDIVIDUAL 8'h04
`define MBID_CONFORMITY 8'h51
`define MBID_MORE_FOLLOWS 8'h00
`define MBID_NEXT_OBJECT 8'h00
`define MBID_LAST_OBJECT 2'h2
`define MBID_EXC_FLAG 8'h80
`define MBID_EXC_ILLEGAL_FN 8'h01
`define MBID_EXC_BAD_ADDR 8'h02
`define MBID_EXC_BAD_VALUE 8'h03
`define MBID_BROADCAST 8'h00
`define MBID_REQ_LEN 8'h07
`define MBID_MIN_LEN 8'h04
`define MBID_HDR_LEN_ID 4'h8
`define MBID_HDR_LEN_EXC 4'h3

// ----------------------------------------------------------------------------
// object text lengths in characters
// ----------------------------------------------------------------------------
`define MBID_LEN_VENDOR 4'h4
`define MBID_LEN_PRODUCT 4'hA
`define MBID_LEN_REVISION 4'h5

// ----------------------------------------------------------------------------
// crc-16
// ----------------------------------------------------------------------------
`define MBID_CRC_INIT 16'hFFFF
`define MBID_CRC_POLY 16'hA001

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define MBID_CLK_NS 100
`define MBID_CHAR_BITS 11
`define MBID_BAUD 9600
// 3.5 characters of 11 bits at 9600 baud, in ns
`define MBID_T35_NS 4010417

`endif
